/* File: design/aid_detect_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aid_consts.svh"

module aid_detect_ctrl
    import aid_pkg::*;
#(
    parameter int US_CYCLES = `AID_CLK_HZ / `AID_US_PER_S
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic [3:0] bias_request_o,
    output logic mic_measure_o,
    input wire logic mic_level_ready_i,
    input wire logic [8:0] mic_level_i,
    output logic hp_sense_left_o,
    output logic hp_sense_right_o,
    output logic [1:0] hp_range_o,
    output logic hp_ramp_rate_o,
    output logic [2:0] hp_hold_o,
    input wire logic hp_result_ready_i,
    input wire logic [9:0] hp_code_i,
    output logic hp_measure_done_event_o,
    output logic hp_measure_done_gpio_o
);

    localparam int TW = `AID_TIMER_W;

    // byte-lane merge of a write into the current register word
    function automatic logic [31:0] aid_merge(
        input logic [31:0] cur,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = cur;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction : aid_merge

    // settle code to microseconds, doubling from 0.25 ms, saturating at 512 ms
    function automatic logic [TW-1:0] aid_settle_us(input logic [3:0] code);
        logic [TW-1:0] v;
        v = `AID_SETTLE_BASE_US;
        if (code == `AID_SETTLE_CONT)
        begin
            v = '0;
        end
        else if (code >= `AID_SETTLE_MAX_CODE)
        begin
            v = `AID_SETTLE_BASE_US << `AID_SETTLE_MAX_SHIFT;
        end
        else
        begin
            v = `AID_SETTLE_BASE_US << (code - 4'h1);
        end
        return v;
    endfunction : aid_settle_us

    // raw bit 0 (<3 ohm) has no enable, so the search always lands when any raw bit is set
    function automatic logic [8:0] aid_band_map(
        input logic [8:0] raw,
        input logic [7:0] en
    );
        logic [8:0] ena;
        logic [8:0] res;
        logic hit;
        logic fall;
        ena = {en, 1'b1};
        res = '0;
        hit = 1'b0;
        fall = 1'b0;
        for (int i = 8; i >= 0; i--)
        begin
            if (raw[i])
            begin
                fall = 1'b1;
            end
            if (fall && ena[i] && !hit)
            begin
                res[i] = 1'b1;
                hit = 1'b1;
            end
        end
        return res;
    endfunction : aid_band_map

    logic ack_r;
    logic [31:0] dat_r;
    logic [1:0] mode_r;
    logic mic_en_r;
    logic [3:0] settle_r;
    logic [2:0] srcen_r;
    logic [1:0] refsel_r;
    logic [7:0] bands_r;
    logic [8:0] level_r;
    logic valid_r;
    logic [1:0] range_r;
    logic [2:0] hold_r;
    logic rate_r;
    logic done_r;
    logic [9:0] code_r;
    logic event_r;
    logic gpio_r;
    logic [3:0] bias_r;
    logic meas_r;
    logic left_r;
    logic right_r;
    aid_mic_state_t mic_st_r;
    aid_mic_state_t mic_st_nxt;
    aid_hp_state_t hp_st_r;
    aid_hp_state_t hp_st_nxt;
    logic tmr_load;
    logic [TW-1:0] tmr_val;
    logic [TW-1:0] tmr_remain;
    logic tmr_expired;
    logic mic_capture;
    logic hp_finish;
    logic [31:0] rd_word;

    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr_stb = bus_req && wb_we_i;
    wire sel_mode = (wb_adr_i == `AID_ADR_MODE);
    wire sel_mcfg = (wb_adr_i == `AID_ADR_MIC_CFG);
    wire sel_bands = (wb_adr_i == `AID_ADR_BANDS);
    wire sel_msts = (wb_adr_i == `AID_ADR_MIC_STS);
    wire sel_hpcfg = (wb_adr_i == `AID_ADR_HP_CFG);
    wire sel_hsts = (wb_adr_i == `AID_ADR_HP_STS);

    wire [31:0] mode_word = {29'h0, mic_en_r, mode_r};
    wire [31:0] mcfg_word = {16'h0, settle_r, 1'b0, srcen_r, 2'h0, refsel_r, 4'h0};
    wire [31:0] bands_word = {24'h0, bands_r};
    wire [31:0] msts_word = {21'h0, level_r, valid_r, |level_r};
    wire [31:0] hpcfg_word = {21'h0, range_r, 1'b0, hold_r, 3'h0, rate_r, 1'b0};
    wire [31:0] hsts_word = {16'h0, done_r, 5'h0, code_r};

    wire [31:0] mode_w = aid_merge(mode_word, wb_dat_i, wb_sel_i);
    wire [31:0] mcfg_w = aid_merge(mcfg_word, wb_dat_i, wb_sel_i);
    wire [31:0] bands_w = aid_merge(bands_word, wb_dat_i, wb_sel_i);
    wire [31:0] hpcfg_w = aid_merge(hpcfg_word, wb_dat_i, wb_sel_i);

    // mode decode
    wire mode_left = (mode_r == `AID_MODE_HP_LEFT);
    wire mode_right = (mode_r == `AID_MODE_HP_RIGHT);
    wire mode_hp = mode_left || mode_right;
    wire mic_need = !mode_hp && mic_en_r;

    // core supply reference (select 0) has no enable and is always up
    wire [3:0] src_on_vec = {srcen_r, 1'b1};
    wire src_on = src_on_vec[refsel_r];
    wire continuous = src_on || (settle_r == `AID_SETTLE_CONT);
    wire min_done = (tmr_remain <= (`AID_MEAS_MAX_US - `AID_MEAS_MIN_US));

    wire hp_trig = wr_stb && sel_hpcfg && hpcfg_w[`AID_TRIG_BIT];
    // a trigger in mic mode or mid-sweep is dropped
    wire hp_start = hp_trig && mode_hp && (hp_st_r == AID_HP_IDLE);

    always_comb
    begin
        if (sel_mode)
        begin
            rd_word = mode_word;
        end
        else if (sel_mcfg)
        begin
            rd_word = mcfg_word;
        end
        else if (sel_bands)
        begin
            rd_word = bands_word;
        end
        else if (sel_msts)
        begin
            rd_word = msts_word;
        end
        else if (sel_hpcfg)
        begin
            rd_word = hpcfg_word;
        end
        else if (sel_hsts)
        begin
            rd_word = hsts_word;
        end
        else
        begin
            rd_word = 32'h0;
        end
    end

    aid_us_timer #(
        .US_CYCLES(US_CYCLES),
        .TW(TW)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .remain_o(tmr_remain),
        .expired_o(tmr_expired)
    );

    // mic-sense sequence
    always_comb
    begin
        mic_st_nxt = mic_st_r;
        tmr_load = 1'b0;
        tmr_val = '0;
        mic_capture = 1'b0;
        case (mic_st_r)
            AID_MIC_IDLE:
            begin
                if (mic_need)
                begin
                    tmr_load = 1'b1;
                    if (continuous)
                    begin
                        tmr_val = `AID_MEAS_MAX_US;
                        mic_st_nxt = AID_MIC_MEAS;
                    end
                    else
                    begin
                        tmr_val = aid_settle_us(settle_r);
                        mic_st_nxt = AID_MIC_SETTLE;
                    end
                end
            end
            AID_MIC_SETTLE:
            begin
                if (!mic_need)
                begin
                    mic_st_nxt = AID_MIC_IDLE;
                end
                else if (tmr_expired)
                begin
                    tmr_load = 1'b1;
                    tmr_val = `AID_MEAS_MAX_US;
                    mic_st_nxt = AID_MIC_MEAS;
                end
            end
            AID_MIC_MEAS:
            begin
                if (!mic_need)
                begin
                    mic_st_nxt = AID_MIC_IDLE;
                end
                else if ((mic_level_ready_i && min_done) || tmr_expired)
                begin
                    mic_capture = 1'b1;
                    mic_st_nxt = AID_MIC_GAP;
                end
            end
            AID_MIC_GAP:
            begin
                mic_st_nxt = AID_MIC_IDLE;
            end
            default:
            begin
                mic_st_nxt = AID_MIC_IDLE;
            end
        endcase
    end

    // headphone sweep sequence
    always_comb
    begin
        hp_st_nxt = hp_st_r;
        hp_finish = 1'b0;
        case (hp_st_r)
            AID_HP_IDLE:
            begin
                if (hp_start)
                begin
                    hp_st_nxt = AID_HP_SWEEP;
                end
            end
            AID_HP_SWEEP:
            begin
                if (!mode_hp)
                begin
                    hp_st_nxt = AID_HP_IDLE;
                end
                else if (hp_result_ready_i)
                begin
                    hp_finish = 1'b1;
                    hp_st_nxt = AID_HP_IDLE;
                end
            end
            default:
            begin
                hp_st_nxt = AID_HP_IDLE;
            end
        endcase
    end

    // pulsed source stays off in idle and gap states
    wire bias_on = mic_need && (continuous || mic_st_nxt == AID_MIC_SETTLE || mic_st_nxt == AID_MIC_MEAS);
    wire [3:0] bias_nxt = bias_on ? (4'h1 << refsel_r) : 4'h0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else
        begin
            ack_r <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                dat_r <= rd_word;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r <= `AID_MODE_RST;
            mic_en_r <= 1'b0;
            settle_r <= `AID_SETTLE_RST;
            srcen_r <= `AID_SRCEN_RST;
            refsel_r <= `AID_REFSEL_RST;
            bands_r <= `AID_BANDS_RST;
        end
        else if (wr_stb)
        begin
            if (sel_mode)
            begin
                mode_r <= mode_w[`AID_MODE_RNG];
                mic_en_r <= mode_w[`AID_MIC_EN_BIT];
            end
            if (sel_mcfg)
            begin
                settle_r <= mcfg_w[`AID_SETTLE_RNG];
                srcen_r <= mcfg_w[`AID_SRCEN_RNG];
                refsel_r <= mcfg_w[`AID_REFSEL_RNG];
            end
            if (sel_bands)
            begin
                bands_r <= bands_w[`AID_BANDS_RNG];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            range_r <= `AID_RANGE_RST;
            hold_r <= `AID_HOLD_RST;
            rate_r <= `AID_RATE_RST;
        end
        else if (wr_stb && sel_hpcfg)
        begin
            range_r <= hpcfg_w[`AID_RANGE_RNG];
            hold_r <= hpcfg_w[`AID_HOLD_RNG];
            rate_r <= hpcfg_w[`AID_RATE_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mic_st_r <= AID_MIC_IDLE;
            level_r <= 9'h0;
            valid_r <= 1'b0;
            bias_r <= 4'h0;
            meas_r <= 1'b0;
        end
        else
        begin
            mic_st_r <= mic_st_nxt;
            bias_r <= bias_nxt;
            meas_r <= (mic_st_nxt == AID_MIC_MEAS);
            if (mic_capture)
            begin
                level_r <= aid_band_map(mic_level_i, bands_r);
            end
            // valid only while mic sensing stays enabled
            valid_r <= mic_capture || (valid_r && mic_need);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hp_st_r <= AID_HP_IDLE;
            done_r <= 1'b0;
            code_r <= 10'h0;
            event_r <= 1'b0;
            gpio_r <= 1'b0;
            left_r <= 1'b0;
            right_r <= 1'b0;
        end
        else
        begin
            hp_st_r <= hp_st_nxt;
            event_r <= hp_finish;
            left_r <= (hp_st_nxt == AID_HP_SWEEP) && mode_left;
            right_r <= (hp_st_nxt == AID_HP_SWEEP) && mode_right;
            if (hp_finish)
            begin
                done_r <= 1'b1;
                gpio_r <= 1'b1;
                code_r <= hp_code_i;
            end
            else if (hp_start)
            begin
                done_r <= 1'b0;
                gpio_r <= 1'b0;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign bias_request_o = bias_r;
    assign mic_measure_o = meas_r;
    assign hp_sense_left_o = left_r;
    assign hp_sense_right_o = right_r;
    assign hp_range_o = range_r;
    assign hp_ramp_rate_o = rate_r;
    assign hp_hold_o = hold_r;
    assign hp_measure_done_event_o = event_r;
    assign hp_measure_done_gpio_o = gpio_r;

endmodule : aid_detect_ctrl

`default_nettype wire

/* File: design/aid_consts.svh */
`ifndef AID_CONSTS_SVH
`define AID_CONSTS_SVH

// register byte offsets
`define AID_ADR_MODE 8'h00
`define AID_ADR_MIC_CFG 8'h04
`define AID_ADR_BANDS 8'h08
`define AID_ADR_MIC_STS 8'h0c
`define AID_ADR_HP_CFG 8'h10
`define AID_ADR_HP_STS 8'h14

// field positions
`define AID_MODE_RNG 1:0
`define AID_MIC_EN_BIT 2
`define AID_SETTLE_RNG 15:12
`define AID_SRCEN_RNG 10:8
`define AID_REFSEL_RNG 5:4
`define AID_BANDS_RNG 7:0
`define AID_RANGE_RNG 10:9
`define AID_HOLD_RNG 7:5
`define AID_RATE_BIT 1
`define AID_TRIG_BIT 0

// reset values
`define AID_MODE_RST 2'h0
`define AID_SETTLE_RST 4'h1
`define AID_SRCEN_RST 3'h0
`define AID_REFSEL_RST 2'h0
`define AID_BANDS_RST 8'h9f
`define AID_RANGE_RST 2'h0
`define AID_HOLD_RST 3'h1
`define AID_RATE_RST 1'h0

// mode encodings
`define AID_MODE_HP_LEFT 2'h1
`define AID_MODE_HP_RIGHT 2'h2

// settle delay code table
`define AID_SETTLE_CONT 4'h0
`define AID_SETTLE_MAX_CODE 4'hc
`define AID_SETTLE_MAX_SHIFT 4'hb

// timing
`define AID_CLK_HZ 32'h017d7840
`define AID_US_PER_S 32'h000f4240
`define AID_TIMER_W 20
`define AID_SETTLE_BASE_US 20'h000fa
`define AID_MEAS_MIN_US 20'h00064
`define AID_MEAS_MAX_US 20'h001f4

`endif

/* File: design/aid_pkg.sv */
package aid_pkg;

    typedef enum logic [1:0] {
        AID_MIC_IDLE = 2'h0,
        AID_MIC_SETTLE = 2'h1,
        AID_MIC_MEAS = 2'h3,
        AID_MIC_GAP = 2'h2
    } aid_mic_state_t;

    typedef enum logic {
        AID_HP_IDLE = 1'h0,
        AID_HP_SWEEP = 1'h1
    } aid_hp_state_t;

endpackage : aid_pkg

/* File: design/aid_us_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module aid_us_timer
    import aid_pkg::*;
#(
    parameter int US_CYCLES = 25,
    parameter int TW = 20
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [TW-1:0] load_val_i,
    output logic [TW-1:0] remain_o,
    output logic expired_o
);

    localparam int PW = $clog2(US_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(US_CYCLES - 1);

    logic [PW-1:0] pre_r;
    logic [TW-1:0] cnt_r;
    wire tick = (pre_r == PRE_LAST);

    // prescaler restarts on load so every delay is at least its full length
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_r <= '0;
            cnt_r <= '0;
        end
        else if (load_i)
        begin
            pre_r <= '0;
            cnt_r <= load_val_i;
        end
        else
        begin
            pre_r <= tick ? '0 : pre_r + 1'b1;
            if (tick && cnt_r != '0)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign remain_o = cnt_r;
    assign expired_o = (cnt_r == '0);

endmodule : aid_us_timer

`default_nettype wire

/* File: test/aid_detect_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aid_consts.svh"
module aid_detect_ctrl_asserts #(
    parameter int US_CYCLES = 25
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [3:0] bias_request_o,
    input wire logic mic_measure_o,
    input wire logic hp_sense_left_o,
    input wire logic hp_sense_right_o,
    input wire logic hp_result_ready_i,
    input wire logic hp_measure_done_event_o,
    input wire logic hp_measure_done_gpio_o
);
    localparam int MEAS_MAX = 501 * US_CYCLES;
    logic [15:0] meas_cnt_r;
    logic [15:0] meas_cnt_nxt;
    logic hp_on;
    assign hp_on = hp_sense_left_o | hp_sense_right_o;
    assign meas_cnt_nxt = mic_measure_o ? meas_cnt_r + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_i)
    begin
        meas_cnt_r <= rst_i ? 16'h0000 : meas_cnt_nxt;
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    AST_ONE_CHANNEL: assert property (!(hp_sense_left_o && hp_sense_right_o))
        else $error("both sense channels active");
    AST_ONE_FUNCTION: assert property (!(mic_measure_o && hp_on))
        else $error("mic and headphone detection together");
    AST_BIAS_MEAS: assert property (mic_measure_o |-> $onehot(bias_request_o))
        else $error("measuring without one bias request");
    AST_DONE_SET: assert property (hp_on && hp_result_ready_i |=>
        hp_measure_done_gpio_o && hp_measure_done_event_o && !hp_on)
        else $error("sweep end not flagged");
    AST_EVENT_PULSE: assert property (hp_measure_done_event_o |=> !hp_measure_done_event_o)
        else $error("event longer than one cycle");
    AST_DONE_HOLD: assert property (!$past(rst_i) && $fell(hp_measure_done_gpio_o) |-> ##[0:1] hp_on)
        else $error("done cleared without new sweep");
    AST_SENSE_CAUSE: assert property ($rose(hp_on) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `AID_ADR_HP_CFG && wb_dat_i[`AID_TRIG_BIT]))
        else $error("sweep started without trigger");
    AST_MEAS_MAX: assert property (mic_measure_o |-> meas_cnt_r <= MEAS_MAX)
        else $error("mic measurement too long");
endmodule : aid_detect_ctrl_asserts
bind aid_detect_ctrl aid_detect_ctrl_asserts #(.US_CYCLES(US_CYCLES)) i_chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bias_request_o, .mic_measure_o, .hp_sense_left_o, .hp_sense_right_o,
    .hp_result_ready_i, .hp_measure_done_event_o, .hp_measure_done_gpio_o);
`default_nettype wire

/* File: test/aid_load_model.sv */
`timescale 1ns/100ps
`default_nettype none
module aid_load_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mic_measure_i,
    input wire logic hp_sense_i,
    input wire logic [8:0] band_i,
    input wire logic [9:0] code_i,
    input wire logic [9:0] delay_i,
    output logic mic_level_ready_o,
    output logic [8:0] mic_level_o,
    output logic hp_result_ready_o,
    output logic [9:0] hp_code_o
);
    logic [9:0] wait_r;
    logic mic_hit;
    logic hp_hit;
    assign mic_hit = mic_measure_i && wait_r >= delay_i;
    assign hp_hit = hp_sense_i && wait_r == delay_i;
    // data lines invert every cycle outside a valid window so a stale value never holds for two cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wait_r <= 10'h000;
            mic_level_ready_o <= 1'b0;
            mic_level_o <= 9'h155;
            hp_result_ready_o <= 1'b0;
            hp_code_o <= 10'h2aa;
        end
        else
        begin
            wait_r <= (mic_measure_i || hp_sense_i) ? wait_r + 10'h001 : 10'h000;
            mic_level_ready_o <= mic_hit;
            mic_level_o <= mic_hit ? band_i : ~mic_level_o;
            hp_result_ready_o <= hp_hit;
            hp_code_o <= hp_hit ? code_i : ~hp_code_o;
        end
    end
endmodule : aid_load_model
`default_nettype wire

/* File: test/test_accessory_impedance_detect.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aid_consts.svh"
module test_accessory_impedance_detect;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic [3:0] bias_request_o;
    logic [8:0] mic_level_i;
    logic [1:0] hp_range_o;
    logic [2:0] hp_hold_o;
    logic [9:0] hp_code_i;
    logic wb_ack_o, mic_measure_o, mic_level_ready_i, hp_sense_left_o, hp_sense_right_o;
    logic hp_ramp_rate_o, hp_result_ready_i, hp_measure_done_event_o, hp_measure_done_gpio_o;
    logic [8:0] load_band = 9'h0;
    logic [9:0] load_code = 10'h0;
    logic [9:0] load_dly = 10'h078;
    logic [31:0] q;
    int bad_count = 0, num_checks = 0, cyc_cnt = 0, ev_cnt = 0, n;

    // one clock per microsecond keeps the settle and measure windows short
    aid_detect_ctrl #(.US_CYCLES(1)) i_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bias_request_o, .mic_measure_o, .mic_level_ready_i, .mic_level_i,
        .hp_sense_left_o, .hp_sense_right_o, .hp_range_o, .hp_ramp_rate_o, .hp_hold_o, .hp_result_ready_i, .hp_code_i,
        .hp_measure_done_event_o, .hp_measure_done_gpio_o);
    aid_load_model i_load (.clk_i, .rst_i, .mic_measure_i(mic_measure_o),
        .hp_sense_i(hp_sense_left_o | hp_sense_right_o), .band_i(load_band), .code_i(load_code), .delay_i(load_dly),
        .mic_level_ready_o(mic_level_ready_i), .mic_level_o(mic_level_i), .hp_result_ready_o(hp_result_ready_i),
        .hp_code_o(hp_code_i));

    always #20 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (hp_measure_done_event_o === 1'b1)
            ev_cnt++;
        if (cyc_cnt == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        check("ack_lat", k, 32'h2);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wait_for(input int which, input logic v);
        logic s;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
            s = which == 0 ? mic_measure_o : which == 1 ? |bias_request_o : hp_measure_done_gpio_o;
        end while (s !== v && n < 2000);
        check("wait", {31'h0, s}, {31'h0, v});
    endtask : wait_for

    task automatic t_regs();
        logic [7:0] adr [6] = '{`AID_ADR_MODE, `AID_ADR_MIC_CFG, `AID_ADR_BANDS, `AID_ADR_HP_CFG, `AID_ADR_HP_STS, 8'h20};
        logic [31:0] want [6] = '{32'h0, 32'h1000, 32'h9f, 32'h20, 32'h0, 32'h0};
        wb(1'b1, 8'h20, 32'hffff_ffff);
        wb(1'b1, `AID_ADR_HP_STS, 32'hffff_ffff);
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b0, adr[i], 32'h0);
            check("reg", q, want[i]);
        end
    endtask : t_regs

    task automatic t_settle();
        wb(1'b1, `AID_ADR_MIC_CFG, 32'h1010);
        wb(1'b1, `AID_ADR_MODE, 32'h4);
        wait_for(1, 1'b1);
        check("bias_sel", {28'h0, bias_request_o}, 32'h2);
        wait_for(0, 1'b1);
        check("settle", {31'h0, n >= 250}, 32'h1);
        wait_for(0, 1'b0);
        check("bias_gap", {28'h0, bias_request_o}, 32'h0);
        wb(1'b1, `AID_ADR_MIC_CFG, 32'h1110);
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        check("bias_cont", {28'h0, bias_request_o}, 32'h2);
    endtask : t_settle

    task automatic t_bands();
        logic [7:0] bn [7] = '{8'h9f, 8'h9f, 8'h9b, 8'h97, 8'h00, 8'h80, 8'h01};
        logic [8:0] raw [7] = '{9'h100, 9'h020, 9'h008, 9'h010, 9'h100, 9'h020, 9'h004};
        logic [8:0] res [7] = '{9'h100, 9'h020, 9'h004, 9'h008, 9'h001, 9'h001, 9'h002};
        for (int i = 0; i < 7; i++)
        begin
            wb(1'b1, `AID_ADR_MODE, 32'h0);
            wb(1'b1, `AID_ADR_BANDS, {24'h0, bn[i]});
            load_band <= raw[i];
            wb(1'b1, `AID_ADR_MODE, i == 1 ? 32'h7 : 32'h4);
            n = 0;
            do
            begin
                wb(1'b0, `AID_ADR_MIC_STS, 32'h0);
                n++;
            end while (q[1] !== 1'b1 && n < 300);
            check("band", q, {21'h0, res[i], 2'b11});
        end
    endtask : t_bands

    task automatic t_hp();
        logic [9:0] codes [3] = '{10'h05a, 10'h096, 10'h12c};
        logic [1:0] rng;
        int evs;
        load_dly <= 10'h01e;
        for (int ch = 1; ch < 3; ch++)
        begin
            wb(1'b1, `AID_ADR_MODE, 32'(ch));
            rng = 2'h0;
            do
            begin
                load_code <= codes[rng];
                evs = ev_cnt;
                wb(1'b1, `AID_ADR_HP_CFG, {21'h0, rng, 9'h021});
                @(posedge clk_i);
                check("sense", {30'h0, hp_sense_right_o, hp_sense_left_o}, 32'(ch));
                check("cfg", {26'h0, hp_range_o, hp_ramp_rate_o, hp_hold_o}, {26'h0, rng, 1'b0, 3'h1});
                check("gpio_clr", {31'h0, hp_measure_done_gpio_o}, 32'h0);
                wait_for(2, 1'b1);
                repeat (20) @(posedge clk_i);
                check("done_hold", {31'h0, hp_measure_done_gpio_o}, 32'h1);
                check("event", ev_cnt, evs + 1);
                wb(1'b0, `AID_ADR_HP_STS, 32'h0);
                check("result", q, {16'h0, 6'h20, codes[rng]});
                rng++;
            end while (rng < 3 && q[9:0] < (rng == 1 ? 10'h064 : 10'h0a9));
        end
        wb(1'b1, `AID_ADR_MODE, 32'h0);
        wb(1'b1, `AID_ADR_HP_CFG, 32'h21);
        repeat (3) @(posedge clk_i);
        check("refused", {30'h0, hp_sense_right_o, hp_measure_done_gpio_o}, 32'h1);
    endtask : t_hp

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_settle();
        t_bands();
        t_hp();
        complete_run();
    end
endmodule : test_accessory_impedance_detect
`default_nettype wire
